// [src/rac_defs.svh]
// Constants for the register access command interpreter and its master.
// Assumes inclusion by bare name from every file that needs the figures.
`ifndef RAC_DEFS_SVH
`define RAC_DEFS_SVH

// ============================================================
// Command opcodes
`define RAC_OP_RD_ONE   8'h10
`define RAC_OP_RD_BLK   8'h30
`define RAC_OP_WR_ONE   8'h08
`define RAC_OP_WR_BLK   8'h28
`define RAC_OP_SET      8'h18
`define RAC_OP_CLR      8'h20

// ============================================================
// Register map layout
`define RAC_REG_COUNT   64
`define RAC_ADDR_TOP    8'hff
`define RAC_MAP_MASK    64'hffff_ffff_55d7_aabf
`define RAC_REG_RST     8'h00
`define RAC_DEV_ADDR_RST 7'h10

`endif

// [src/rac_dev.sv]
// Device end: opcode interpreter over a byte register map.
// Assumes the master keeps framing order; one link event per cycle.
// Map of 64 bytes at 00h..3Fh lives in flops; holes read as zero.
`timescale 1ns/1ns
`include "rac_defs.svh"

// Functional notes
// [RULE_01] 10h reads one, 30h reads a block
// [RULE_02] 08h writes one, 28h writes a block
// [RULE_03] Master loads address, then restarts for read
// [RULE_04] Single read repeats same byte
// [RULE_05] Block read advances address each byte
// [RULE_06] Unmapped read location returns zero
// [RULE_07] Past highest register, reads return zero
// [RULE_08] Set/clear sends target, opcode, address, mask
// [RULE_09] 18h sets bits where mask is one
// [RULE_10] 20h clears bits where mask is one
// [RULE_11] Block write stores at ascending addresses
// [RULE_12] Writes to unmapped addresses are dropped
// [RULE_13] Bytes beyond address space are dropped
// [RULE_14] Master ends with stop or restart
// [RULE_15] Bytes after target: opcode, address, data
module rac_dev (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Link to master
  rac_link_if.dev         link,
  // User side
  input  wire logic [6:0] dev_addr,
  input  wire logic [7:0] peek_addr,
  output logic      [7:0] peek_data,
  output logic            wr_stb,
  output logic      [7:0] wr_addr,
  output logic      [7:0] wr_data
);

  // ============================================================
  // State record, filled by the next-state process
  typedef struct packed {
    // Command decode
    rac_pkg::rac_dev_st_t  st;
    logic [7:0]            opc;
    logic [7:0]            ptr;
    logic                  past;
    logic                  blk_rd;
    // Register map
    logic [`RAC_REG_COUNT-1:0][7:0] regs;
    // Registered outputs
    logic                  rd_vld;
    logic [7:0]            rd_byte;
    logic                  wr_stb;
    logic [7:0]            wr_addr;
    logic [7:0]            wr_data;
    logic [7:0]            peek;
  } rac_dev_state_t;

  rac_dev_state_t s_reg;
  rac_dev_state_t s_next;

  // ============================================================
  // Map decode: holes and the region above the map read as absent
  function automatic logic rac_mapped(input logic [7:0] a);
    logic [`RAC_REG_COUNT-1:0] m;
    m = `RAC_MAP_MASK;
    rac_mapped = (a < 8'(`RAC_REG_COUNT)) && m[a[5:0]];
  endfunction : rac_mapped

  // Opcodes that may change a register; others take bytes and drop them
  function automatic logic rac_is_wr(input logic [7:0] op);
    rac_is_wr = (op == `RAC_OP_WR_ONE) || (op == `RAC_OP_WR_BLK) ||
                (op == `RAC_OP_SET) || (op == `RAC_OP_CLR);
  endfunction : rac_is_wr

  // ============================================================
  // Next state
  always_comb
  begin
    // Register under the pointer, shared by set, clear and read
    logic [7:0] cur;
    cur = s_reg.regs[s_reg.ptr[5:0]];
    s_next = s_reg;
    // Strobes default low; peek lags its address by one cycle
    s_next.rd_vld = 1'b0;
    s_next.wr_stb = 1'b0;
    s_next.peek = rac_mapped(peek_addr) ? s_reg.regs[peek_addr[5:0]] : 8'h00;
    // Framing first: start beats stop, stop beats any byte
    if (link.frm_start)
    begin
      s_next.st = rac_pkg::DEV_TGT; // Restart also closes the command
    end
    else if (link.frm_stop)
    begin
      s_next.st = rac_pkg::DEV_IDLE; // [RULE_14]
    end
    else if (link.wr_vld)
    begin
      case (s_reg.st)
        // Wrong target parks the device until the next start
        rac_pkg::DEV_TGT:
        begin
          if (link.wr_byte[7:1] != dev_addr)
            s_next.st = rac_pkg::DEV_IDLE; // Not ours, wait for next start
          else if (link.wr_byte[0])
            s_next.st = rac_pkg::DEV_RDATA; // [RULE_03]
          else
            s_next.st = rac_pkg::DEV_OPC;
        end
        // First byte after the target is the opcode
        rac_pkg::DEV_OPC:
        begin
          s_next.opc = link.wr_byte; // [RULE_15]
          s_next.st  = rac_pkg::DEV_RADDR;
        end
        // Second byte loads the pointer and rearms the end flag
        rac_pkg::DEV_RADDR:
        begin
          s_next.ptr  = link.wr_byte; // [RULE_15]
          s_next.past = 1'b0;
          s_next.st   = rac_pkg::DEV_DATA;
          // Read mode survives until the next address load of a read opcode
          if (s_reg.opc == `RAC_OP_RD_ONE)
            s_next.blk_rd = 1'b0; // [RULE_01]
          else if (s_reg.opc == `RAC_OP_RD_BLK)
            s_next.blk_rd = 1'b1; // [RULE_01]
        end
        rac_pkg::DEV_DATA:
        begin
          // Writes land only on mapped, in-space addresses
          if (rac_mapped(s_reg.ptr) && !s_reg.past) // [RULE_12] [RULE_13]
          begin
            // Set and clear merge the mask into the current byte
            case (s_reg.opc)
              `RAC_OP_WR_ONE, `RAC_OP_WR_BLK: // [RULE_02]
                s_next.regs[s_reg.ptr[5:0]] = link.wr_byte;
              `RAC_OP_SET:
                s_next.regs[s_reg.ptr[5:0]] = cur | link.wr_byte; // [RULE_09] [RULE_08]
              `RAC_OP_CLR:
                s_next.regs[s_reg.ptr[5:0]] = cur & ~link.wr_byte; // [RULE_10] [RULE_08]
              default: ;
            endcase
            // Strobe carries the value that now stands in the register
            if (rac_is_wr(s_reg.opc))
            begin
              s_next.wr_stb  = 1'b1;
              s_next.wr_addr = s_reg.ptr;
              s_next.wr_data = s_next.regs[s_reg.ptr[5:0]];
            end
          end
          // Block write walks upward, never wraps past the top
          // Hazard: wrapping from FFh would land on mapped 00h
          if (s_reg.opc == `RAC_OP_WR_BLK) // [RULE_11]
          begin
            if (s_reg.ptr == `RAC_ADDR_TOP)
              s_next.past = 1'b1; // [RULE_13]
            else
              s_next.ptr = s_reg.ptr + 8'h01;
          end
          else
            s_next.past = 1'b1; // Single ops take one byte only
        end
        // Idle and read states take no write bytes
        default: ;
      endcase
    end
    // Read answer one cycle after the request, zero outside the map
    else if (link.rd_req && (s_reg.st == rac_pkg::DEV_RDATA))
    begin
      s_next.rd_vld  = 1'b1;
      s_next.rd_byte = (rac_mapped(s_reg.ptr) && !s_reg.past) ? cur
                                                               : 8'h00; // [RULE_06] [RULE_07]
      // Single reads hold the pointer, so the same byte repeats
      if (s_reg.blk_rd) // [RULE_04]
      begin
        // Past the top the flag keeps every later byte at zero
        if (s_reg.ptr == `RAC_ADDR_TOP)
          s_next.past = 1'b1; // [RULE_07]
        else
          s_next.ptr = s_reg.ptr + 8'h01; // [RULE_05]
      end
    end
  end

  // ============================================================
  // State register
  // Reset branch loads constants only: empty map, pointer at 00h
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_reg <= '{st: rac_pkg::DEV_IDLE, regs: {`RAC_REG_COUNT{`RAC_REG_RST}},
                 default: '0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ============================================================
  // Outputs, each straight from the state record
  assign link.rd_vld  = s_reg.rd_vld;
  assign link.rd_byte = s_reg.rd_byte;
  assign peek_data    = s_reg.peek;
  assign wr_stb       = s_reg.wr_stb;
  assign wr_addr      = s_reg.wr_addr;
  assign wr_data      = s_reg.wr_data;

endmodule : rac_dev

// [src/rac_host.sv]
// Master end: turns one user command into a framed transaction.
// Assumes the device answers a read request on the next cycle.
`timescale 1ns/1ns
`include "rac_defs.svh"

module rac_host (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Link to device
  rac_link_if.host        link,
  // Command port
  input  wire logic       cmd_vld,
  input  wire logic [7:0] cmd_opc,
  input  wire logic [6:0] cmd_tgt,
  input  wire logic [7:0] cmd_reg,
  input  wire logic [7:0] cmd_len,
  input  wire logic [7:0] wdata,
  // Status and results
  output logic            busy,
  output logic            wdata_take,
  output logic            rdata_vld,
  output logic      [7:0] rdata,
  output logic            done
);

  typedef struct packed {
    rac_pkg::rac_hst_st_t st;
    logic [7:0]           opc;
    logic [6:0]           tgt;
    logic [7:0]           raddr;
    logic [7:0]           left;
    logic                 gap;
    logic                 start;
    logic                 stop;
    logic                 wvld;
    logic [7:0]           wbyte;
    logic                 rreq;
    logic                 busy;
    logic                 take;
    logic                 rvld;
    logic [7:0]           rbyte;
    logic                 done;
  } rac_hst_state_t;

  rac_hst_state_t h_reg;
  rac_hst_state_t h_next;

  // ============================================================
  // Sequencer: every link event is followed by one idle cycle,
  // so a read answer always lands before the next event
  always_comb
  begin
    logic is_rd;
    is_rd = (h_reg.opc == `RAC_OP_RD_ONE) || (h_reg.opc == `RAC_OP_RD_BLK);
    h_next = h_reg;
    h_next.start = 1'b0;
    h_next.stop  = 1'b0;
    h_next.wvld  = 1'b0;
    h_next.rreq  = 1'b0;
    h_next.take  = 1'b0;
    h_next.done  = 1'b0;
    h_next.rvld  = link.rd_vld;
    if (link.rd_vld)
      h_next.rbyte = link.rd_byte;
    if (h_reg.gap)
      h_next.gap = 1'b0;
    else
    begin
      case (h_reg.st)
        rac_pkg::HST_IDLE:
        begin
          if (cmd_vld)
          begin
            h_next.opc   = cmd_opc;
            h_next.tgt   = cmd_tgt;
            h_next.raddr = cmd_reg;
            h_next.left  = (cmd_len == 8'h00) ? 8'h01 : cmd_len;
            h_next.busy  = 1'b1;
            h_next.st    = rac_pkg::HST_START;
          end
        end
        rac_pkg::HST_START:
        begin
          h_next.start = 1'b1;
          h_next.gap   = 1'b1;
          h_next.st    = rac_pkg::HST_TGTW;
        end
        rac_pkg::HST_TGTW:
        begin
          h_next.wvld  = 1'b1;
          h_next.wbyte = {h_reg.tgt, 1'b0};
          h_next.gap   = 1'b1;
          h_next.st    = rac_pkg::HST_OPC;
        end
        rac_pkg::HST_OPC:
        begin
          h_next.wvld  = 1'b1;
          h_next.wbyte = h_reg.opc; // [RULE_15] [RULE_01] [RULE_02]
          h_next.gap   = 1'b1;
          h_next.st    = rac_pkg::HST_RADDR;
        end
        rac_pkg::HST_RADDR:
        begin
          h_next.wvld  = 1'b1;
          h_next.wbyte = h_reg.raddr; // [RULE_15]
          h_next.gap   = 1'b1;
          h_next.st    = is_rd ? rac_pkg::HST_RSTRT : rac_pkg::HST_WDAT; // [RULE_03]
        end
        rac_pkg::HST_WDAT:
        begin
          // Set and clear carry exactly one mask byte
          h_next.wvld  = 1'b1;
          h_next.wbyte = wdata; // [RULE_08] [RULE_11]
          h_next.take  = 1'b1;
          h_next.gap   = 1'b1;
          h_next.left  = h_reg.left - 8'h01;
          if ((h_reg.opc != `RAC_OP_WR_BLK) || (h_reg.left == 8'h01))
            h_next.st = rac_pkg::HST_STOP;
        end
        rac_pkg::HST_RSTRT:
        begin
          h_next.start = 1'b1; // [RULE_03]
          h_next.gap   = 1'b1;
          h_next.st    = rac_pkg::HST_TGTR;
        end
        rac_pkg::HST_TGTR:
        begin
          h_next.wvld  = 1'b1;
          h_next.wbyte = {h_reg.tgt, 1'b1}; // [RULE_03]
          h_next.gap   = 1'b1;
          h_next.st    = rac_pkg::HST_RREQ;
        end
        rac_pkg::HST_RREQ:
        begin
          h_next.rreq = 1'b1;
          h_next.gap  = 1'b1;
          h_next.left = h_reg.left - 8'h01;
          if (h_reg.left == 8'h01)
            h_next.st = rac_pkg::HST_STOP;
        end
        rac_pkg::HST_STOP:
        begin
          h_next.stop = 1'b1; // [RULE_14]
          h_next.busy = 1'b0;
          h_next.done = 1'b1;
          h_next.st   = rac_pkg::HST_IDLE;
        end
        default:
          h_next.st = rac_pkg::HST_IDLE;
      endcase
    end
  end

  // ============================================================
  // State register
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      h_reg <= '{st: rac_pkg::HST_IDLE, default: '0};
    end
    else
    begin
      h_reg <= h_next;
    end
  end

  assign link.frm_start = h_reg.start;
  assign link.frm_stop  = h_reg.stop;
  assign link.wr_vld    = h_reg.wvld;
  assign link.wr_byte   = h_reg.wbyte;
  assign link.rd_req    = h_reg.rreq;
  assign busy           = h_reg.busy;
  assign wdata_take     = h_reg.take;
  assign rdata_vld      = h_reg.rvld;
  assign rdata          = h_reg.rbyte;
  assign done           = h_reg.done;

endmodule : rac_host

// [src/rac_link_if.sv]
// Byte-level frame link between the bus master and the device.
// Assumes both ends share sys_clk; the master drives framing and bytes.
`timescale 1ns/1ns
interface rac_link_if;
  logic       frm_start;  // Start or repeated start, pulse
  logic       frm_stop;   // Stop, pulse
  logic       wr_vld;     // Byte from master, pulse
  logic [7:0] wr_byte;
  logic       rd_req;     // Master clocks out one byte, pulse
  logic       rd_vld;     // Device answer, one cycle after rd_req
  logic [7:0] rd_byte;

  modport dev  (input frm_start, frm_stop, wr_vld, wr_byte, rd_req,
                output rd_vld, rd_byte);
  modport host (output frm_start, frm_stop, wr_vld, wr_byte, rd_req,
                input rd_vld, rd_byte);
endinterface : rac_link_if

// [src/rac_pkg.sv]
// Types shared by both ends of the register access link.
// Assumes rac_defs.svh sits on the include path.
package rac_pkg;

  // ============================================================
  // Device end states, one-hot
  typedef enum logic [5:0] {
    DEV_IDLE  = 6'h01,
    DEV_TGT   = 6'h02,
    DEV_OPC   = 6'h04,
    DEV_RADDR = 6'h08,
    DEV_DATA  = 6'h10,
    DEV_RDATA = 6'h20
  } rac_dev_st_t;

  // ============================================================
  // Master end states, one-hot
  typedef enum logic [9:0] {
    HST_IDLE  = 10'h001,
    HST_START = 10'h002,
    HST_TGTW  = 10'h004,
    HST_OPC   = 10'h008,
    HST_RADDR = 10'h010,
    HST_WDAT  = 10'h020,
    HST_RSTRT = 10'h040,
    HST_TGTR  = 10'h080,
    HST_RREQ  = 10'h100,
    HST_STOP  = 10'h200
  } rac_hst_st_t;

endpackage : rac_pkg

// [testbench/i2c_register_access_cmd_test.sv]
// Self-checking bench: master end drives device end over the link.
// Assumes rac_defs.svh on the include path; one 100 MHz clock.
`timescale 1ns/1ns
`include "rac_defs.svh"

module i2c_register_access_cmd_test;
  logic       sys_clk;
  logic       arst_n;
  logic [6:0] dev_addr;
  logic [7:0] peek_addr;
  logic [7:0] peek_data;
  logic       cmd_vld;
  logic [7:0] cmd_opc;
  logic [6:0] cmd_tgt;
  logic [7:0] cmd_reg;
  logic [7:0] cmd_len;
  logic [7:0] wdata;
  logic       busy;
  logic       wdata_take;
  logic       rdata_vld;
  logic [7:0] rdata;
  logic       done;
  logic       wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [15:0] wq [$];
  logic [7:0] mdl [256];
  logic [7:0] wbuf [256];
  logic [7:0] rq [$];
  logic [31:0] seed;
  int          widx;
  int          bad_count;
  int          compares;
  // Corner cases: fill, map end, space end, unmapped, set, clear
  logic [7:0] c_op [11] = '{`RAC_OP_WR_BLK, `RAC_OP_RD_BLK, `RAC_OP_WR_BLK, `RAC_OP_RD_BLK,
    `RAC_OP_WR_BLK, `RAC_OP_RD_BLK, `RAC_OP_WR_ONE, `RAC_OP_RD_ONE, `RAC_OP_SET,
    `RAC_OP_CLR, `RAC_OP_RD_ONE};
  logic [7:0] c_ra [11] = '{8'h00, 8'h00, 8'h3c, 8'h3c, 8'hfc, 8'hfd, 8'h06, 8'h06, 8'h10,
    8'h10, 8'h10};
  logic [7:0] c_len [11] = '{8'h40, 8'h40, 8'h08, 8'h08, 8'h06, 8'h06, 8'h01, 8'h01, 8'h01,
    8'h01, 8'h05};

  // ============================================================
  // Design ends and link
  rac_link_if link ();
  rac_dev i_rac_dev (.sys_clk(sys_clk), .arst_n(arst_n), .link(link), .dev_addr(dev_addr),
    .peek_addr(peek_addr), .peek_data(peek_data), .wr_stb(wr_stb), .wr_addr(wr_addr),
    .wr_data(wr_data));
  rac_host i_rac_host (.sys_clk(sys_clk), .arst_n(arst_n), .link(link), .cmd_vld(cmd_vld),
    .cmd_opc(cmd_opc), .cmd_tgt(cmd_tgt), .cmd_reg(cmd_reg), .cmd_len(cmd_len),
    .wdata(wdata), .busy(busy), .wdata_take(wdata_take), .rdata_vld(rdata_vld),
    .rdata(rdata), .done(done));
  rac_link_assertions i_rac_link_assertions (.sys_clk(sys_clk), .arst_n(arst_n),
    .frm_start(link.frm_start), .frm_stop(link.frm_stop), .wr_vld(link.wr_vld),
    .wr_byte(link.wr_byte), .rd_req(link.rd_req), .rd_vld(link.rd_vld),
    .rd_byte(link.rd_byte));

  // ============================================================
  // Expectation helpers
  function automatic logic mapped(input logic [8:0] a);
    return (a < 9'h040) && (((`RAC_MAP_MASK >> a[5:0]) & 64'h1) != 64'h0);
  endfunction : mapped

  function automatic logic [7:0] rexp(input logic [8:0] a);
    return mapped(a) ? mdl[a[7:0]] : 8'h00;
  endfunction : rexp

  // Galois step; repeatable from the fixed seed
  function logic [7:0] rnd();
    seed = {1'b0, seed[31:1]} ^ (seed[0] ? 32'h8020_0003 : 32'h0);
    return seed[7:0];
  endfunction : rnd

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  // Register contents through the peek port, one cycle latency
  task automatic sweep();
    for (int i = 0; i < 66; i++)
    begin
      @(posedge sys_clk);
      peek_addr <= (i == 65) ? 8'hff : 8'(i);
      repeat (2) @(posedge sys_clk);
      #1 check("peek", peek_data, rexp((i == 65) ? 9'h0ff : 9'(i)));
    end
  endtask : sweep

  // One command through the master, then model update and read compare
  task automatic run(input logic [7:0] opc, input logic [7:0] ra, input logic [7:0] len,
                     input logic [6:0] tgt);
    int         n;
    int         k;
    int         m;
    logic       rd;
    logic [8:0] a;
    rd = (opc == `RAC_OP_RD_ONE) || (opc == `RAC_OP_RD_BLK);
    // Single reads still clock len bytes, each a copy of one register
    n = (rd || opc == `RAC_OP_WR_BLK) ? ((len == 8'h00) ? 1 : int'(len)) : 1;
    m = 0;
    rq.delete();
    wq.delete();
    @(posedge sys_clk);
    cmd_vld <= 1'b1;
    cmd_opc <= opc;
    cmd_reg <= ra;
    cmd_len <= len;
    cmd_tgt <= tgt;
    wdata   <= wbuf[0];
    widx    <= 0;
    @(posedge sys_clk);
    cmd_vld <= 1'b0;
    #1 check("busy", {7'h00, busy}, 8'h01);
    k = 0;
    while (done !== 1'b1 && k < 1000)
    begin
      @(posedge sys_clk);
      #1 k++;
    end
    check("done", {7'h00, done}, 8'h01);
    @(posedge sys_clk);
    #1;
    if (tgt != dev_addr)
    begin
      check("wr count", 8'(wq.size()), 8'h00);
      return;
    end
    if (opc == `RAC_OP_RD_ONE || opc == `RAC_OP_RD_BLK)
      check("rd count", 8'(rq.size()), 8'(n));
    for (int i = 0; i < n; i++)
    begin
      a = (opc == `RAC_OP_RD_ONE) ? 9'(ra) : 9'(ra) + 9'(i);
      case (opc)
        `RAC_OP_WR_ONE, `RAC_OP_WR_BLK: if (mapped(a)) mdl[a[7:0]] = wbuf[i];
        `RAC_OP_SET: if (mapped(a)) mdl[a[7:0]] = mdl[a[7:0]] | wbuf[0];
        `RAC_OP_CLR: if (mapped(a)) mdl[a[7:0]] = mdl[a[7:0]] & ~wbuf[0];
        default:
          check("rdata", (i < rq.size()) ? rq[i] : 8'hxx, rexp(a));
      endcase
      // Every landed write strobes once with the value now held
      if (!rd && mapped(a))
      begin
        check("wr addr", (m < wq.size()) ? wq[m][15:8] : 8'hxx, a[7:0]);
        check("wr data", (m < wq.size()) ? wq[m][7:0] : 8'hxx, mdl[a[7:0]]);
        m++;
      end
    end
    check("wr count", 8'(wq.size()), 8'(m));
  endtask : run

  // ============================================================
  // Clock, collectors and watchdog
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Read bytes and write strobes queued; next data byte staged after each take
  always @(posedge sys_clk)
  begin
    if (rdata_vld === 1'b1)
      rq.push_back(rdata);
    if (wr_stb === 1'b1)
      wq.push_back({wr_addr, wr_data});
    if (wdata_take === 1'b1)
    begin
      wdata <= wbuf[(widx + 1) % 256];
      widx  <= widx + 1;
    end
  end

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    complete_run();
  end

  // ============================================================
  // Main sequence
  initial
  begin
    logic [7:0] op;
    logic [7:0] ra;
    logic [7:0] ln;
    logic [6:0] tg;
    seed = 32'he40a;
    arst_n = 1'b0;
    dev_addr = `RAC_DEV_ADDR_RST;
    peek_addr = 8'h00;
    cmd_vld = 1'b0;
    cmd_opc = 8'h00;
    cmd_tgt = 7'h00;
    cmd_reg = 8'h00;
    cmd_len = 8'h00;
    wdata = 8'h00;
    widx = 0;
    bad_count = 0;
    compares = 0;
    foreach (mdl[i]) mdl[i] = `RAC_REG_RST;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    sweep();
    for (int k = 0; k < 52; k++)
    begin
      foreach (wbuf[i]) wbuf[i] = rnd();
      op = (k < 11) ? c_op[k] : c_op[rnd() % 8'd6 + 8'd4];
      ra = rnd();
      ra = (k < 11) ? c_ra[k] : (ra[7] ? ra : {2'b00, ra[5:0]});
      ln = (k < 11) ? c_len[k] : (rnd() & 8'h07);
      tg = dev_addr;
      // Wrong target: the whole write must leave the map alone
      if (k == 11)
      begin
        op = `RAC_OP_WR_BLK;
        tg = dev_addr ^ 7'h01;
      end
      run(op, ra, ln, tg);
      sweep();
      $display("test %0d done op %h reg %h", k, op, ra);
    end
    complete_run();
  end
endmodule : i2c_register_access_cmd_test

// [testbench/rac_link_assertions.sv]
// Checker for the byte link between the master end and the device end.
// Assumes instantiation beside the link interface, all signals on sys_clk.
`timescale 1ns/1ns

module rac_link_assertions (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       arst_n,
  // Link signals
  input wire logic       frm_start,
  input wire logic       frm_stop,
  input wire logic       wr_vld,
  input wire logic [7:0] wr_byte,
  input wire logic       rd_req,
  input wire logic       rd_vld,
  input wire logic [7:0] rd_byte
);
  // ============================================================
  // Shared clock and reset
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  // Any master event; spacing keeps the device one event per cycle
  logic ev;
  assign ev = frm_start | frm_stop | wr_vld | rd_req;

  // ============================================================
  // Framing and answers
  ev_spacing_a: assert property (ev |=> !ev)
    else $error("link events back to back");
  start_target_a: assert property (frm_start |-> ##2 wr_vld)
    else $error("no target byte after start");
  start_no_stop_a: assert property (frm_start |=> (!frm_stop) [*3])
    else $error("stop too soon after start");
  read_answer_a: assert property (rd_req |=> rd_vld)
    else $error("read request not answered");
  answer_cause_a: assert property (rd_vld |-> $past(rd_req))
    else $error("answer without request");
  wbyte_hold_a: assert property ($changed(wr_byte) |-> wr_vld)
    else $error("write byte moved without valid");
  rbyte_hold_a: assert property ($changed(rd_byte) |-> rd_vld)
    else $error("read byte moved without answer");
  answer_follow_a: assert property (rd_vld |-> ##[1:2] (rd_req | frm_stop | frm_start))
    else $error("read frame left hanging");
endmodule : rac_link_assertions
